// ### verilog/prs_status_regs.v
// Raw condition register bank with APB slave and change-event interrupt.
// Assumes condition inputs come from analog/other-domain sources and are
// synchronised here; APB master is on clk.
//
// Overview of operation
// - Global bit 3 reads one when sync clock frequency is invalid.
// - Global bit 2 reads one while die is above thermal shutdown.
// - Global bit 1 reads one while die is above thermal warning.
// - Global bit 0 reads one while input is above overvoltage threshold.
// - Step-down bits 7 and 3 show second and first converter enables.
// - Step-down bits 6 and 2 show live output-valid conditions.
// - Step-down bits 4 and 0 show live current-limit conditions.
// - Step-up bit 3 reads one while step-up converter is enabled.
// - Step-up bit 2 shows live step-up output-valid condition.
// - Step-up bit 0 shows live step-up current-limit condition.
// - Monitor bit 4 follows second external monitored voltage validity.
// - Monitor bit 2 follows first external monitored voltage validity.
// - Monitor bit 0 follows analog supply input validity.
// - All four condition registers read-only and zero after reset.
// - Interrupt masks never alter the live condition bits.
`timescale 1ns/10ps
`default_nettype none
`include "prs_consts.vh"

module prs_status_regs
(
  input  wire        clk,
  input  wire        rst,
  input  wire        sync_clock_bad,
  input  wire        overtemp_shutdown_level,
  input  wire        overtemp_warning_level,
  input  wire        input_overvoltage_level,
  input  wire        first_step_down_enabled,
  input  wire        second_step_down_enabled,
  input  wire        first_step_down_output_ok,
  input  wire        second_step_down_output_ok,
  input  wire        first_step_down_at_limit,
  input  wire        second_step_down_at_limit,
  input  wire        step_up_enabled,
  input  wire        step_up_output_ok,
  input  wire        step_up_at_limit,
  input  wire        first_monitor_ok,
  input  wire        second_monitor_ok,
  input  wire        analog_supply_ok,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: every condition is asynchronous to clk, so each
  // level passes its own two-flop stage before any logic reads it
  wire sync_clock_bad_s;
  wire overtemp_shutdown_s;
  wire overtemp_warning_s;
  wire input_overvoltage_s;
  wire first_en_s;
  wire second_en_s;
  wire first_ok_s;
  wire second_ok_s;
  wire first_lim_s;
  wire second_lim_s;
  wire step_up_en_s;
  wire step_up_ok_s;
  wire step_up_lim_s;
  wire first_mon_s;
  wire second_mon_s;
  wire analog_ok_s;

  prs_sync2 sync_clk_bad_u
  (
    .clk (clk),
    .rst (rst),
    .d   (sync_clock_bad),
    .q   (sync_clock_bad_s)
  );

  prs_sync2 sync_tsd_u
  (
    .clk (clk),
    .rst (rst),
    .d   (overtemp_shutdown_level),
    .q   (overtemp_shutdown_s)
  );

  prs_sync2 sync_twarn_u
  (
    .clk (clk),
    .rst (rst),
    .d   (overtemp_warning_level),
    .q   (overtemp_warning_s)
  );

  prs_sync2 sync_ovp_u
  (
    .clk (clk),
    .rst (rst),
    .d   (input_overvoltage_level),
    .q   (input_overvoltage_s)
  );

  prs_sync2 sync_en0_u
  (
    .clk (clk),
    .rst (rst),
    .d   (first_step_down_enabled),
    .q   (first_en_s)
  );

  prs_sync2 sync_en1_u
  (
    .clk (clk),
    .rst (rst),
    .d   (second_step_down_enabled),
    .q   (second_en_s)
  );

  prs_sync2 sync_ok0_u
  (
    .clk (clk),
    .rst (rst),
    .d   (first_step_down_output_ok),
    .q   (first_ok_s)
  );

  prs_sync2 sync_ok1_u
  (
    .clk (clk),
    .rst (rst),
    .d   (second_step_down_output_ok),
    .q   (second_ok_s)
  );

  prs_sync2 sync_lim0_u
  (
    .clk (clk),
    .rst (rst),
    .d   (first_step_down_at_limit),
    .q   (first_lim_s)
  );

  prs_sync2 sync_lim1_u
  (
    .clk (clk),
    .rst (rst),
    .d   (second_step_down_at_limit),
    .q   (second_lim_s)
  );

  prs_sync2 sync_su_en_u
  (
    .clk (clk),
    .rst (rst),
    .d   (step_up_enabled),
    .q   (step_up_en_s)
  );

  prs_sync2 sync_su_ok_u
  (
    .clk (clk),
    .rst (rst),
    .d   (step_up_output_ok),
    .q   (step_up_ok_s)
  );

  prs_sync2 sync_su_lim_u
  (
    .clk (clk),
    .rst (rst),
    .d   (step_up_at_limit),
    .q   (step_up_lim_s)
  );

  prs_sync2 sync_mon1_u
  (
    .clk (clk),
    .rst (rst),
    .d   (first_monitor_ok),
    .q   (first_mon_s)
  );

  prs_sync2 sync_mon2_u
  (
    .clk (clk),
    .rst (rst),
    .d   (second_monitor_ok),
    .q   (second_mon_s)
  );

  prs_sync2 sync_ana_u
  (
    .clk (clk),
    .rst (rst),
    .d   (analog_supply_ok),
    .q   (analog_ok_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Live condition registers, assembled from the synchronised levels
  reg [7:0] global_nxt;
  reg [7:0] step_down_nxt;
  reg [7:0] step_up_nxt;
  reg [7:0] monitor_nxt;

  // Reserved positions stay zero because nothing ever sets them
  always @*
  begin
    global_nxt    = `PRS_RESET_VAL;
    step_down_nxt = `PRS_RESET_VAL;
    step_up_nxt   = `PRS_RESET_VAL;
    monitor_nxt   = `PRS_RESET_VAL;
    global_nxt[`PRS_GC_SYNC_BAD] = sync_clock_bad_s;
    global_nxt[`PRS_GC_TSD]      = overtemp_shutdown_s;
    global_nxt[`PRS_GC_TWARN]    = overtemp_warning_s;
    global_nxt[`PRS_GC_OVP]      = input_overvoltage_s;
    step_down_nxt[`PRS_SD_EN0]   = first_en_s;
    step_down_nxt[`PRS_SD_EN1]   = second_en_s;
    step_down_nxt[`PRS_SD_OK0]   = first_ok_s;
    step_down_nxt[`PRS_SD_OK1]   = second_ok_s;
    step_down_nxt[`PRS_SD_LIM0]  = first_lim_s;
    step_down_nxt[`PRS_SD_LIM1]  = second_lim_s;
    step_up_nxt[`PRS_SU_EN]      = step_up_en_s;
    step_up_nxt[`PRS_SU_OK]      = step_up_ok_s;
    step_up_nxt[`PRS_SU_LIM]     = step_up_lim_s;
    monitor_nxt[`PRS_MI_MON1]    = first_mon_s;
    monitor_nxt[`PRS_MI_MON2]    = second_mon_s;
    monitor_nxt[`PRS_MI_ANA]     = analog_ok_s;
  end

  reg [7:0] global_condition_flags_r;
  reg [7:0] step_down_state_r;
  reg [7:0] step_up_state_r;
  reg [7:0] monitor_input_state_r;

  // Registers track hardware only; no bus path writes them
  always @(posedge clk)
  begin
    if (rst)
    begin
      global_condition_flags_r <= `PRS_RESET_VAL;
      step_down_state_r        <= `PRS_RESET_VAL;
      step_up_state_r          <= `PRS_RESET_VAL;
      monitor_input_state_r    <= `PRS_RESET_VAL;
    end
    else
    begin
      global_condition_flags_r <= global_nxt;
      step_down_state_r        <= step_down_nxt;
      step_up_state_r          <= step_up_nxt;
      monitor_input_state_r    <= monitor_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change events: one sticky bit per condition register
  reg  [3:0] evt_stat_r;
  reg  [3:0] evt_mask_r;
  wire [3:0] evt_hit;
  wire       wr_acc;
  wire [9:0] widx;

  // Any change of a register's live value counts as its event
  assign evt_hit = {monitor_nxt   != monitor_input_state_r,
                    step_up_nxt   != step_up_state_r,
                    step_down_nxt != step_down_state_r,
                    global_nxt    != global_condition_flags_r};

  assign wr_acc = psel & penable & pwrite;
  assign widx   = paddr[11:2];

  // Set beats a simultaneous write-one clear so no event is lost
  always @(posedge clk)
  begin
    if (rst)
    begin
      evt_stat_r <= `PRS_EVT_RESET;
      evt_mask_r <= `PRS_MASK_RESET;
    end
    else
    begin
      if (wr_acc && widx == {2'b00, `PRS_IDX_EVT_STAT})
        evt_stat_r <= (evt_stat_r & ~pwdata[3:0]) | evt_hit;
      else
        evt_stat_r <= evt_stat_r | evt_hit;
      if (wr_acc && widx == {2'b00, `PRS_IDX_EVT_MASK})
        evt_mask_r <= pwdata[3:0];
    end
  end

  // Mask gates only the interrupt, never the condition bits
  assign irq = |(evt_stat_r & evt_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped reads return zero
  reg [31:0] rdata_nxt;
  wire       rd_setup;

  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Read decode; writes to condition registers fall through unused
  always @*
  begin
    rdata_nxt = `PRS_ZERO32;
    if (paddr[11:2] == {2'b00, `PRS_IDX_GLOBAL})
      rdata_nxt = {24'h00_0000, global_condition_flags_r};
    else if (paddr[11:2] == {2'b00, `PRS_IDX_STEP_DOWN})
      rdata_nxt = {24'h00_0000, step_down_state_r};
    else if (paddr[11:2] == {2'b00, `PRS_IDX_STEP_UP})
      rdata_nxt = {24'h00_0000, step_up_state_r};
    else if (paddr[11:2] == {2'b00, `PRS_IDX_MONITOR})
      rdata_nxt = {24'h00_0000, monitor_input_state_r};
    else if (paddr[11:2] == {2'b00, `PRS_IDX_EVT_STAT})
      rdata_nxt = {28'h000_0000, evt_stat_r};
    else if (paddr[11:2] == {2'b00, `PRS_IDX_EVT_MASK})
      rdata_nxt = {28'h000_0000, evt_mask_r};
  end

  // Read data captured in setup so it is a flop during access
  always @(posedge clk)
  begin
    if (rst)
      prdata <= `PRS_ZERO32;
    else if (rd_setup)
      prdata <= rdata_nxt;
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for one asynchronous level input
module prs_sync2
(
  input  wire clk,
  input  wire rst,
  input  wire d,
  output reg  q
);

  reg meta_r;

  // Only q feeds logic; meta_r may settle late after a metastable sample
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= `PRS_LVL_RESET;
      q      <= `PRS_LVL_RESET;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ### inc/prs_consts.vh
// Constants for the raw condition register bank: offsets, bit positions,
// reset values and the event interrupt register layout.
// Assumes inclusion by bare name from the design files.
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH

// Register indices as printed; byte address is four times the index
`define PRS_IDX_GLOBAL    8'h25
`define PRS_IDX_STEP_DOWN 8'h26
`define PRS_IDX_STEP_UP   8'h27
`define PRS_IDX_MONITOR   8'h28
`define PRS_IDX_EVT_STAT  8'h30
`define PRS_IDX_EVT_MASK  8'h31

// Global condition bits
`define PRS_GC_SYNC_BAD   3
`define PRS_GC_TSD        2
`define PRS_GC_TWARN      1
`define PRS_GC_OVP        0
// Step-down state bits
`define PRS_SD_EN1        7
`define PRS_SD_OK1        6
`define PRS_SD_LIM1       4
`define PRS_SD_EN0        3
`define PRS_SD_OK0        2
`define PRS_SD_LIM0       0
// Step-up state bits
`define PRS_SU_EN         3
`define PRS_SU_OK         2
`define PRS_SU_LIM        0
// Monitor input state bits
`define PRS_MI_MON2       4
`define PRS_MI_MON1       2
`define PRS_MI_ANA        0

`define PRS_REG_W         8
`define PRS_RESET_VAL     8'h00
`define PRS_LVL_RESET     1'b0
`define PRS_ZERO32        32'h0000_0000
`define PRS_EVT_RESET     4'h0
`define PRS_MASK_RESET    4'h0

`endif

// ### dv/prs_status_checker.sv
// Checker for the raw condition register bank, watching top ports only.
// Assumes one clock and synchronous active-high reset; bound by name.
`timescale 1ns/10ps
`default_nettype none
module prs_status_checker
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sync_clock_bad,
  input wire logic        overtemp_warning_level,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read setup of the global register, where prdata is loaded
  wire rd_su = psel && !penable && !pwrite;
  wire rd_gl = rd_su && (paddr == 12'h094);
  ////////////////////////////////////////////////////////////////////////////
  pready_high_a: assert property (pready) else $error("pready low");
  no_slverr_a: assert property (!pslverr) else $error("pslverr set");
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !prdata)
    else $error("prdata not cleared by reset");
  reserved_zero_a: assert property (rd_gl |=> !prdata[31:4])
    else $error("reserved bits set");
  // Five steady cycles cover the two-stage sync plus the register
  warn_live_a: assert property (overtemp_warning_level [*5] ##0 rd_gl
    |=> prdata[1]) else $error("warning bit missing");
  sync_good_a: assert property ((!sync_clock_bad) [*5] ##0 rd_gl
    |=> !prdata[3]) else $error("sync bit wrongly set");
  unmapped_zero_a: assert property (rd_su && paddr == 12'h000 |=> !prdata)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_su |=> $stable(prdata))
    else $error("prdata moved outside read setup");
  cover property (rd_gl);
  cover property (psel && penable && pwrite && paddr == 12'h0C0);
  cover property (overtemp_warning_level && rd_gl);
endmodule
bind prs_status_regs prs_status_checker chk_u
(
  .clk(clk), .rst(rst), .sync_clock_bad(sync_clock_bad),
  .overtemp_warning_level(overtemp_warning_level), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr)
);
`default_nettype wire

// ### dv/prs_status_regs_test.sv
// Testbench for the raw condition register bank over APB.
// Assumes pready may stall; every wait is bounded.
`timescale 1ns/10ps
`default_nettype none
module prs_status_regs_test;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, a;
  logic [31:0] pwdata = 0, q;
  logic [15:0] cond = 0;
  logic [15:0] pat [4] = '{16'hFFFF, 16'hAAAA, 16'h5555, 16'h0000};
  wire         pready, pslverr, irq;
  wire  [31:0] prdata;
  integer      err_total = 0, total_checks = 0, i, p;
  prs_status_regs dut_u
  (
    .clk(clk), .rst(rst), .sync_clock_bad(cond[0]),
    .overtemp_shutdown_level(cond[1]), .overtemp_warning_level(cond[2]),
    .input_overvoltage_level(cond[3]),
    .first_step_down_enabled(cond[4]), .second_step_down_enabled(cond[5]),
    .first_step_down_output_ok(cond[6]),
    .second_step_down_output_ok(cond[7]),
    .first_step_down_at_limit(cond[8]), .second_step_down_at_limit(cond[9]),
    .step_up_enabled(cond[10]), .step_up_output_ok(cond[11]),
    .step_up_at_limit(cond[12]), .first_monitor_ok(cond[13]),
    .second_monitor_ok(cond[14]), .analog_supply_ok(cond[15]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq)
  );
  initial
    forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    begin
      total_checks++;
      if (s !== e)
      begin
        err_total++;
        $display("ERROR %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // Opens on a fresh edge so no signal is assigned twice in a time step
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (n = 0; n < 16; n++)
      begin
        @(posedge clk);
        if (pready === 1'b1)
          break;
      end
      if (n == 16)
      begin
        err_total++;
        test_done;
      end
      q = prdata;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rdc(input logic [11:0] ad, input string nm, input logic [31:0] e);
    begin
      apb(0, ad, 32'h0000_0000);
      chk(nm, q, e);
    end
  endtask
  // Register image from the condition vector, reserved bits zero
  function automatic logic [31:0] ex(input logic [15:0] c, input integer r);
    case (r)
      0: ex = {28'h000_0000, c[0], c[1], c[2], c[3]};
      1: ex = {24'h00_0000, c[5], c[7], 1'b0, c[9], c[4], c[6], 1'b0, c[8]};
      2: ex = {28'h000_0000, c[10], c[11], 1'b0, c[12]};
      default: ex = {27'h000_0000, c[14], 1'b0, c[13], 1'b0, c[15]};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 4; i++)
      rdc(12'h094 + 12'(4 * i), "reset", 32'h0000_0000);
    rdc(12'h0C0, "evt reset", 32'h0000_0000);
    rdc(12'h0C4, "mask reset", 32'h0000_0000);
    // Patterns drive all ones, alternate bits, then all zeros; a write of ones must not stick
    for (p = 0; p < 4; p++)
    begin
      cond <= pat[p];
      repeat (5) @(posedge clk);
      for (i = 0; i < 4; i++)
      begin
        a = 12'h094 + 12'(4 * i);
        apb(1, a, 32'hFFFF_FFFF);
        rdc(a, "cond", ex(pat[p], i));
      end
    end
    apb(1, 12'h0C0, 32'h0000_000F);
    rdc(12'h0C0, "evt clear", 32'h0000_0000);
    cond <= 16'h0004;
    repeat (5) @(posedge clk);
    chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
    rdc(12'h0C0, "evt global", 32'h0000_0001);
    rdc(12'h094, "masked warn", 32'h0000_0002);
    apb(1, 12'h0C4, 32'h0000_0001);
    rdc(12'h0C4, "mask", 32'h0000_0001);
    chk("irq on", {31'h0000_0000, irq}, 32'h0000_0001);
    apb(1, 12'h0C0, 32'h0000_0001);
    rdc(12'h0C0, "evt w1c", 32'h0000_0000);
    chk("irq off", {31'h0000_0000, irq}, 32'h0000_0000);
    rdc(12'h000, "unmapped", 32'h0000_0000);
    test_done;
  end
endmodule
`default_nettype wire
